//--- design/synce_clock_selector.v
// Purpose: equipment-clock selector with input monitors, hardware
//          restore/holdoff timers, digital PLL and output synthesizers
// Assumes: clk_sys is the reference_pll_clock, 250 MHz
// Notes:   inputs are sampled on clk_sys, so usable input rates stay
//          below half of clk_sys
`include "synce_selector_regs.vh"

// Notes on behaviour
// - pick the active reference from four inputs by software priority
// - on loss of the active input move to next eligible by priority
// - with no eligible input left, enter holdover
// - four monitors judge long-term, short-term accuracy and missing edges
// - learn frequency history while locked, replay it in holdover
// - switch references without a phase step on the outputs
// - restore and holdoff timers run in hardware on a ms tick
// - inputs run below 125 MHz, synthesizers cover 1 MHz to 31.25 MHz
// - loop corner set by equipment-clock option 1 or option 2
// - each synthesizer follows the controller or one input directly
// - software offset against selected input or free-running frequency
// - output phase adjustable apart from frequency
// - loop bandwidth programmable down to about one millihertz
// - synthesizer 0 drives the transmit clock, others drive outside
// - synthesizer 3 makes the time-domain clock when domains are split
// - controller timing comes from the reference PLL clock
// - frequency and time domains are kept apart only when CTRL_SEPARATE_TIME is set
module synce_clock_selector
#(
  parameter MS_TICK_CYCLES = `MS_NS / `CLK_PERIOD_NS
)
(
  // clock and reset
  input wire clk_sys,
  input wire rst,
  // register port
  input wire [7:0] reg_addr,
  input wire [31:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [31:0] reg_rdata,
  // candidate clocks and link state
  input wire [3:0] ref_in,
  input wire [3:0] link_up,
  input wire ref_pll_locked,
  // clock outputs
  output reg [3:0] synth_clk,
  output reg tx_clk,
  output reg time_clk,
  // status
  output reg [1:0] selected,
  output reg holdover,
  output reg irq
);

localparam ST_FREE = 2'h0;
localparam ST_LOCK = 2'h1;
localparam ST_HOLDOFF = 2'h2;
localparam ST_HOLDOVER = 2'h3;

function [23:0] absdiff;
  input [23:0] a;
  input [23:0] b;
  begin
    absdiff = (a > b) ? a - b : b - a;
  end
endfunction

// lowest-numbered priority slot (slot 0 first) holding an eligible input wins
function [2:0] best_pick;
  input [3:0] el;
  input [7:0] pr;
  integer k;
  reg [1:0] c;
  begin
    best_pick = 3'h0;
    for (k = 3; k >= 0; k = k - 1)
    begin
      c = pr[2*k +: 2];
      if (el[c])
        best_pick = {1'b1, c};
    end
  end
endfunction

// --------------------------------------------------------------------------
// input synchronisers
// --------------------------------------------------------------------------
reg [3:0] ref_s1, ref_s2, ref_s3, link_s1, link_s2;
reg lock_s1, lock_s2;
wire [3:0] ref_edge = ref_s2 & ~ref_s3;

always @(posedge clk_sys)
begin
  if (rst)
  begin
    ref_s1 <= 4'h0;
    ref_s2 <= 4'h0;
    ref_s3 <= 4'h0;
    link_s1 <= 4'h0;
    link_s2 <= 4'h0;
    lock_s1 <= 1'b0;
    lock_s2 <= 1'b0;
  end
  else
  begin
    ref_s1 <= ref_in;
    ref_s2 <= ref_s1;
    ref_s3 <= ref_s2;
    link_s1 <= link_up;
    link_s2 <= link_s1;
    lock_s1 <= ref_pll_locked;
    lock_s2 <= lock_s1;
  end
end

// --------------------------------------------------------------------------
// registers and timers
// --------------------------------------------------------------------------
reg [31:0] ctrl, prio, bw, win_len, wtr_len, holdoff_len, miss_len, tol;
reg [31:0] int_stat, int_mask;
reg [31:0] expect_cnt [0:3];
reg [3:0] scfg [0:3];
reg [15:0] phase_pend [0:3];
reg [3:0] phase_req;
reg [31:0] tick_cnt;
reg tick;
reg [23:0] win_cnt, short_cnt;
reg win_end, short_end;
reg [23:0] cnt_long [0:3];
reg [23:0] cnt_short [0:3];
reg [15:0] miss_cnt [0:3];
reg [15:0] wtr_cnt [0:3];
reg signed [23:0] err [0:3];
reg [3:0] long_ok, short_ok, miss_bad, elig, qual_d;
reg [1:0] st;
reg [15:0] hold_cnt;
reg signed [31:0] freq_corr, hist;
reg [1:0] scan, scan_d;
reg [31:0] acc [0:3];
reg ev_holdover, ev_switch;
integer i, si, ri;

wire [3:0] qual_raw = long_ok & short_ok & ~miss_bad & link_s2 &
  ~ctrl[`CTRL_SSM_LO +: 4] & {4{lock_s2}};
wire syn_hit = (reg_addr >= `ADDR_SYNTH_LO) && (reg_addr <= `ADDR_SYNTH_HI);
wire [1:0] syn_idx = reg_addr[3:2];
wire [1:0] syn_fld = reg_addr[1:0];
wire [1:0] exp_idx = reg_addr[1:0];
wire exp_hit = (reg_addr >= `ADDR_EXPECT_LO) && (reg_addr <= `ADDR_EXPECT_HI);
wire [31:0] w1c = (reg_wr && reg_addr == `ADDR_INT_STAT) ? reg_wdata : 32'h0;
wire [2:0] pick = best_pick(elig, prio[7:0]);
wire enable = ctrl[`CTRL_ENABLE];
wire [31:0] status_word = {19'h0, lock_s2, elig, qual_raw, st, selected};

always @(posedge clk_sys)
begin
  if (rst)
  begin
    tick_cnt <= 32'h0;
    tick <= 1'b0;
    win_cnt <= 24'h0;
    short_cnt <= 24'h0;
    win_end <= 1'b0;
    short_end <= 1'b0;
  end
  else
  begin
    tick <= (tick_cnt == MS_TICK_CYCLES - 1);
    tick_cnt <= (tick_cnt == MS_TICK_CYCLES - 1) ? 32'h0 : tick_cnt + 32'h1;
    win_end <= (win_cnt >= win_len[23:0]);
    win_cnt <= (win_cnt >= win_len[23:0]) ? 24'h0 : win_cnt + 24'h1;
    short_end <= (short_cnt >= (win_len[23:0] >> `SHORT_SHIFT));
    short_cnt <= (short_cnt >= (win_len[23:0] >> `SHORT_SHIFT)) ?
      24'h0 : short_cnt + 24'h1;
  end
end

// --------------------------------------------------------------------------
// input monitors and wait-to-restore
// --------------------------------------------------------------------------
always @(posedge clk_sys)
begin
  if (rst)
  begin
    long_ok <= 4'h0;
    short_ok <= 4'h0;
    miss_bad <= 4'hf;
    elig <= 4'h0;
    qual_d <= 4'h0;
    for (i = 0; i < 4; i = i + 1)
    begin
      cnt_long[i] <= 24'h0;
      cnt_short[i] <= 24'h0;
      miss_cnt[i] <= 16'h0;
      wtr_cnt[i] <= 16'h0;
      err[i] <= 24'sh0;
    end
  end
  else
  begin
    qual_d <= qual_raw;
    for (i = 0; i < 4; i = i + 1)
    begin
      if (win_end)
      begin
        long_ok[i] <= absdiff(cnt_long[i], expect_cnt[i][23:0]) <=
          tol[23:0] && expect_cnt[i][23:0] != 24'h0;
        err[i] <= $signed(cnt_long[i] - expect_cnt[i][23:0]);
        cnt_long[i] <= {23'h0, ref_edge[i]};
      end
      else
        cnt_long[i] <= cnt_long[i] + {23'h0, ref_edge[i]};
      if (short_end)
      begin
        short_ok[i] <= absdiff(cnt_short[i],
          expect_cnt[i][23:0] >> `SHORT_SHIFT) <= {8'h0, tol[31:16]};
        cnt_short[i] <= {23'h0, ref_edge[i]};
      end
      else
        cnt_short[i] <= cnt_short[i] + {23'h0, ref_edge[i]};
      miss_cnt[i] <= ref_edge[i] ? 16'h0 : miss_cnt[i] + 16'h1;
      miss_bad[i] <= !ref_edge[i] && miss_cnt[i] >= miss_len[15:0];
      if (!qual_raw[i])
      begin
        elig[i] <= 1'b0;
        wtr_cnt[i] <= wtr_len[15:0];
      end
      else if (wtr_cnt[i] == 16'h0)
        elig[i] <= 1'b1;
      else if (tick)
        wtr_cnt[i] <= wtr_cnt[i] - 16'h1;
    end
  end
end

// --------------------------------------------------------------------------
// selection state machine and digital PLL
// --------------------------------------------------------------------------
wire [4:0] bw_eff = (bw[4:0] == 5'h0) ? (ctrl[`CTRL_OPTION2] ?
  `BW_SHIFT_OPT2 : `BW_SHIFT_OPT1) :
  ((bw[4:0] > `BW_SHIFT_MAX) ? `BW_SHIFT_MAX : bw[4:0]);
wire signed [31:0] err_sel = {{8{err[selected][23]}}, err[selected]};
wire signed [31:0] loop_step = (err_sel <<< `DPLL_GAIN) >>> bw_eff;
wire signed [31:0] corr_out = (st == ST_LOCK) ? freq_corr : hist;

always @(posedge clk_sys)
begin
  if (rst)
  begin
    st <= ST_FREE;
    selected <= 2'h0;
    holdover <= 1'b0;
    hold_cnt <= 16'h0;
    freq_corr <= 32'sh0;
    hist <= 32'sh0;
    ev_holdover <= 1'b0;
    ev_switch <= 1'b0;
  end
  else
  begin
    ev_holdover <= 1'b0;
    ev_switch <= 1'b0;
    holdover <= (st == ST_HOLDOVER);
    if (st == ST_LOCK && win_end)
    begin
      freq_corr <= freq_corr + loop_step;
      hist <= hist + ((freq_corr - hist) >>> `HIST_SHIFT);
    end
    if (!enable)
      st <= ST_FREE;
    else
    begin
      case (st)
        ST_FREE:
          if (lock_s2 && pick[2])
          begin
            st <= ST_LOCK;
            selected <= pick[1:0];
            freq_corr <= hist;
          end
        ST_LOCK:
          if (!elig[selected])
          begin
            st <= ST_HOLDOFF;
            hold_cnt <= holdoff_len[15:0];
          end
          else if (pick[2] && pick[1:0] != selected)
          begin
            selected <= pick[1:0];
            ev_switch <= 1'b1;
          end
        ST_HOLDOFF:
          if (elig[selected])
            st <= ST_LOCK;
          else if (hold_cnt == 16'h0)
          begin
            if (pick[2])
            begin
              st <= ST_LOCK;
              selected <= pick[1:0];
              ev_switch <= 1'b1;
            end
            else
            begin
              st <= ST_HOLDOVER;
              ev_holdover <= 1'b1;
            end
          end
          else if (tick)
            hold_cnt <= hold_cnt - 16'h1;
        default:
          if (pick[2])
          begin
            st <= ST_LOCK;
            selected <= pick[1:0];
            freq_corr <= hist;
            ev_switch <= 1'b1;
          end
      endcase
    end
  end
end

// --------------------------------------------------------------------------
// output synthesizers, one updated per clock in turn
// --------------------------------------------------------------------------
wire [31:0] base_word, off_word;
wire syn_wr = reg_wr && syn_hit;

synth_word_mem #(.WIDTH(32), .ADDR_W(2)) u_base_mem
(
  .clk_sys(clk_sys),
  .rst(rst),
  .wr_en(syn_wr && syn_fld == `FIELD_BASE),
  .wr_addr(syn_idx),
  .wr_data(reg_wdata),
  .rd_addr(scan),
  .rd_data(base_word)
);

synth_word_mem #(.WIDTH(32), .ADDR_W(2)) u_off_mem
(
  .clk_sys(clk_sys),
  .rst(rst),
  .wr_en(syn_wr && syn_fld == `FIELD_OFFSET),
  .wr_addr(syn_idx),
  .wr_data(reg_wdata),
  .rd_addr(scan),
  .rd_data(off_word)
);

wire [3:0] cfg_s = scfg[scan_d];
wire [23:0] err_dir = err[cfg_s[`SCFG_SEL_LO +: 2]];
wire signed [31:0] dir_corr = {{8{err_dir[23]}}, err_dir} <<< `DPLL_GAIN;
wire [31:0] track = cfg_s[`SCFG_DIRECT] ? dir_corr :
  (cfg_s[`SCFG_OFFSET_REL] ? corr_out : 32'h0);
wire [31:0] raw_inc = base_word + off_word + track;
wire [31:0] inc = (raw_inc < `INC_MIN) ? `INC_MIN : raw_inc;
wire [31:0] phase_add = phase_req[scan_d] ?
  {phase_pend[scan_d], 16'h0} : 32'h0;
wire [31:0] next_acc = acc[scan_d] + (inc << `SYNTH_STEP_SHIFT) +
  phase_add;

always @(posedge clk_sys)
begin
  if (rst)
  begin
    scan <= 2'h0;
    scan_d <= 2'h0;
    synth_clk <= 4'h0;
    tx_clk <= 1'b0;
    time_clk <= 1'b0;
    for (si = 0; si < 4; si = si + 1)
      acc[si] <= 32'h0;
  end
  else
  begin
    scan <= scan + 2'h1;
    scan_d <= scan;
    acc[scan_d] <= next_acc;
    synth_clk[scan_d] <= next_acc[31];
    if (scan_d == 2'h0)
      tx_clk <= next_acc[31];
    // both modes update in the synthesizer 0 slot, so a mode change
    // cannot cut a time_clk phase short
    if (scan_d == 2'h0)
      time_clk <= ctrl[`CTRL_SEPARATE_TIME] ?
        synth_clk[3] : next_acc[31];
  end
end

// --------------------------------------------------------------------------
// register port and interrupt
// --------------------------------------------------------------------------
always @(posedge clk_sys)
begin
  if (rst)
  begin
    ctrl <= `RST_CTRL;
    prio <= `RST_PRIO;
    bw <= `RST_BW;
    win_len <= `RST_WINDOW;
    wtr_len <= `RST_WTR;
    holdoff_len <= `RST_HOLDOFF;
    miss_len <= `RST_MISSING;
    tol <= `RST_TOL;
    int_stat <= 32'h0;
    int_mask <= 32'h0;
    phase_req <= 4'h0;
    irq <= 1'b0;
    reg_rdata <= 32'h0;
    for (ri = 0; ri < 4; ri = ri + 1)
    begin
      expect_cnt[ri] <= `RST_EXPECT;
      scfg[ri] <= 4'h0;
      phase_pend[ri] <= 16'h0;
    end
  end
  else
  begin
    // events win over a write-one clear in the same cycle
    int_stat <= (int_stat & ~w1c) | {29'h0, qual_raw != qual_d,
      ev_switch, ev_holdover};
    irq <= |(int_stat & int_mask);
    phase_req[scan_d] <= 1'b0;
    if (reg_wr)
    begin
      if (reg_addr == `ADDR_CTRL)
        ctrl <= reg_wdata;
      else if (reg_addr == `ADDR_PRIO)
        prio <= reg_wdata;
      else if (reg_addr == `ADDR_BW)
        bw <= reg_wdata;
      else if (reg_addr == `ADDR_WINDOW)
        win_len <= reg_wdata;
      else if (reg_addr == `ADDR_WTR)
        wtr_len <= reg_wdata;
      else if (reg_addr == `ADDR_HOLDOFF)
        holdoff_len <= reg_wdata;
      else if (reg_addr == `ADDR_MISSING)
        miss_len <= reg_wdata;
      else if (reg_addr == `ADDR_TOL)
        tol <= reg_wdata;
      else if (exp_hit)
        expect_cnt[exp_idx] <= reg_wdata;
      else if (reg_addr == `ADDR_INT_MASK)
        int_mask <= reg_wdata;
      else if (syn_hit && syn_fld == `FIELD_PHASE)
      begin
        phase_pend[syn_idx] <= reg_wdata[15:0];
        phase_req[syn_idx] <= 1'b1;
      end
      else if (syn_hit && syn_fld == `FIELD_CFG)
        scfg[syn_idx] <= reg_wdata[3:0];
    end
    if (reg_rd)
    begin
      if (reg_addr == `ADDR_CTRL)
        reg_rdata <= ctrl;
      else if (reg_addr == `ADDR_PRIO)
        reg_rdata <= prio;
      else if (reg_addr == `ADDR_BW)
        reg_rdata <= bw;
      else if (reg_addr == `ADDR_WINDOW)
        reg_rdata <= win_len;
      else if (reg_addr == `ADDR_WTR)
        reg_rdata <= wtr_len;
      else if (reg_addr == `ADDR_HOLDOFF)
        reg_rdata <= holdoff_len;
      else if (reg_addr == `ADDR_MISSING)
        reg_rdata <= miss_len;
      else if (reg_addr == `ADDR_TOL)
        reg_rdata <= tol;
      else if (exp_hit)
        reg_rdata <= expect_cnt[exp_idx];
      else if (reg_addr == `ADDR_STATUS)
        reg_rdata <= status_word;
      else if (reg_addr == `ADDR_INT_STAT)
        reg_rdata <= int_stat;
      else if (reg_addr == `ADDR_INT_MASK)
        reg_rdata <= int_mask;
      else if (reg_addr == `ADDR_HOLD_FREQ)
        reg_rdata <= hist;
      else if (syn_hit && syn_fld == `FIELD_CFG)
        reg_rdata <= {28'h0, scfg[syn_idx]};
      else
        reg_rdata <= 32'h0;
    end
    else
      reg_rdata <= 32'h0;
  end
end

endmodule // synce_clock_selector

//--- design/synce_selector_regs.vh
// Purpose: register offsets, field positions, reset values and timing
//          constants for the clock selector
// Assumes: word addresses on an 8-bit register port
// Notes:   synthesizer words sit at 0x10..0x1f, four words per synthesizer
`ifndef SYNCE_SELECTOR_REGS_VH
`define SYNCE_SELECTOR_REGS_VH

// --------------------------------------------------------------------------
// register offsets
// --------------------------------------------------------------------------
`define ADDR_CTRL 8'h00
`define ADDR_PRIO 8'h01
`define ADDR_BW 8'h02
`define ADDR_WINDOW 8'h03
`define ADDR_WTR 8'h04
`define ADDR_HOLDOFF 8'h05
`define ADDR_MISSING 8'h06
`define ADDR_TOL 8'h07
`define ADDR_EXPECT_LO 8'h08
`define ADDR_EXPECT_HI 8'h0b
`define ADDR_STATUS 8'h0c
`define ADDR_INT_STAT 8'h0d
`define ADDR_INT_MASK 8'h0e
`define ADDR_HOLD_FREQ 8'h0f
`define ADDR_SYNTH_LO 8'h10
`define ADDR_SYNTH_HI 8'h1f

// --------------------------------------------------------------------------
// fields
// --------------------------------------------------------------------------
`define CTRL_ENABLE 0
`define CTRL_OPTION2 1
`define CTRL_SEPARATE_TIME 2
`define CTRL_SSM_LO 4
`define FIELD_BASE 2'h0
`define FIELD_OFFSET 2'h1
`define FIELD_PHASE 2'h2
`define FIELD_CFG 2'h3
`define SCFG_DIRECT 0
`define SCFG_SEL_LO 1
`define SCFG_OFFSET_REL 3
`define INT_HOLDOVER 0
`define INT_SWITCH 1
`define INT_QUAL 2

// --------------------------------------------------------------------------
// reset values
// --------------------------------------------------------------------------
`define RST_CTRL 32'h00000000
`define RST_PRIO 32'h000000e4
`define RST_BW 32'h00000000
`define RST_WINDOW 32'h00002710
`define RST_WTR 32'h00000005
`define RST_HOLDOFF 32'h00000003
`define RST_MISSING 32'h00000100
`define RST_TOL 32'h00040010
`define RST_EXPECT 32'h00000fa0

// --------------------------------------------------------------------------
// timing and loop constants
// --------------------------------------------------------------------------
`define CLK_PERIOD_NS 4
`define MS_NS 1000000
`define SHORT_SHIFT 4
`define DPLL_GAIN 16
`define HIST_SHIFT 8
`define BW_SHIFT_OPT1 5'h08
`define BW_SHIFT_OPT2 5'h0c
`define BW_SHIFT_MAX 5'h18
`define INC_MIN 32'h010624dd
`define PHASE_LSB 16
`define SYNTH_STEP_SHIFT 2

`endif

//--- design/synth_word_mem.v
// Purpose: small word store for synthesizer settings
// Assumes: one write port, one read port with registered data
// Notes:   read data follow the address by one clock
module synth_word_mem
#(
  parameter WIDTH = 32,
  parameter ADDR_W = 2
)
(
  // clock and reset
  input wire clk_sys,
  input wire rst,
  // write port
  input wire wr_en,
  input wire [ADDR_W-1:0] wr_addr,
  input wire [WIDTH-1:0] wr_data,
  // read port
  input wire [ADDR_W-1:0] rd_addr,
  output reg [WIDTH-1:0] rd_data
);

reg [WIDTH-1:0] mem [0:(1<<ADDR_W)-1];
integer k;

// cleared on reset so an unwritten synthesizer never accumulates garbage
always @(posedge clk_sys)
begin
  if (rst)
  begin
    for (k = 0; k < (1 << ADDR_W); k = k + 1)
      mem[k] <= {WIDTH{1'b0}};
  end
  else if (wr_en)
  begin
    mem[wr_addr] <= wr_data;
  end
end

always @(posedge clk_sys)
begin
  if (rst)
  begin
    rd_data <= {WIDTH{1'b0}};
  end
  else
  begin
    rd_data <= mem[rd_addr];
  end
end

endmodule // synth_word_mem

//--- sim/ref_clock_model.sv
// Purpose: candidate clocks offered to the selector
// Assumes: all sources at one nominal rate, 62.5 MHz
// Notes:   a stopped source holds its pin low
module ref_clock_model
#(
  parameter HALF_NS = 8
)
(
  // control from bench
  input wire [3:0] run,
  // candidate clocks
  output logic [3:0] ref_in
);
  timeunit 1ns;
  timeprecision 100ps;
  logic osc;
  // own oscillator, phase unrelated to clk_sys
  initial
  begin
    osc = 1'b0;
    #1.3;
    forever #(HALF_NS) osc = ~osc;
  end
  always @(osc or run) ref_in = run & {4{osc}};
endmodule // ref_clock_model

//--- sim/synce_clock_selector_asserts.sv
// Purpose: port-level checks for the clock selector
// Assumes: one clk_sys domain, synchronous active-high rst
// Notes:   bound to the top module at the foot of this file
`include "synce_selector_regs.vh"
module synce_clock_selector_asserts
(
  // clock and reset
  input wire clk_sys,
  input wire rst,
  // register port
  input wire [7:0] reg_addr,
  input wire reg_rd,
  input wire [31:0] reg_rdata,
  // candidates, outputs and status
  input wire [3:0] link_up,
  input wire [3:0] synth_clk,
  input wire tx_clk,
  input wire time_clk,
  input wire [1:0] selected,
  input wire holdover
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  // ------------------------------------------------------------
  // sequences
  // ------------------------------------------------------------
  // a synthesizer clock moves at most once per four cycles
  sequence s_quiet(sig);
    $stable(sig) [*3];
  endsequence
  sequence s_status_read;
    reg_rd && reg_addr == `ADDR_STATUS && $stable(selected);
  endsequence
  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  a_rdata_idle: assert property (
    !reg_rd |=> reg_rdata == 32'h0) else $error("read data outside read");
  a_unmapped_zero: assert property (
    reg_rd && reg_addr > `ADDR_SYNTH_HI |=> reg_rdata == 32'h0)
    else $error("unmapped read not zero");
  a_status_sel: assert property (
    s_status_read |=> $stable(selected) |-> reg_rdata[1:0] == selected)
    else $error("status disagrees with selected");
  a_tx_rate: assert property (
    $changed(tx_clk) |=> s_quiet(tx_clk)) else $error("tx clock too fast");
  a_time_rate: assert property (
    $changed(time_clk) |=> s_quiet(time_clk))
    else $error("time clock too fast");
  a_tx_source: assert property (
    tx_clk == synth_clk[0] || tx_clk == $past(synth_clk[0]))
    else $error("tx clock not from synthesizer 0");
  a_time_source: assert property (
    time_clk == synth_clk[0] || time_clk == $past(synth_clk[0]) ||
    time_clk == synth_clk[3] || time_clk == $past(synth_clk[3]))
    else $error("time clock from wrong synthesizer");
  a_loss_delay: assert property (
    $fell(link_up[selected]) && !holdover |=> $stable(selected) [*2])
    else $error("loss acted on too early");
endmodule // synce_clock_selector_asserts

bind synce_clock_selector synce_clock_selector_asserts checker_inst (
  .clk_sys(clk_sys), .rst(rst), .reg_addr(reg_addr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .link_up(link_up), .synth_clk(synth_clk),
  .tx_clk(tx_clk), .time_clk(time_clk), .selected(selected),
  .holdover(holdover));

//--- sim/synce_clock_selector_bench.sv
// Purpose: self-checking bench for the clock selector
// Assumes: ms tick shortened to 10 cycles, 400-cycle window
// Notes:   random words from a 16-bit lfsr seeded with 53397
`include "synce_selector_regs.vh"
module synce_clock_selector_bench;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk_sys, rst, reg_wr, reg_rd, ref_pll_locked;
  logic [7:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata, d;
  logic [3:0] ref_in, link_up, run, synth_clk;
  logic tx_clk, time_clk, holdover, irq, t;
  logic [1:0] selected;
  logic [15:0] lfsr;
  int mismatches, tests_run, n;
  int cycles = 0;
  logic [7:0] ra [11] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h05,
    8'h06, 8'h07, 8'h08, 8'h0d, 8'h30};
  logic [31:0] rv [11] = '{32'h0, 32'he4, 32'h0, 32'h2710, 32'h5, 32'h3,
    32'h100, 32'h40010, 32'hfa0, 32'h0, 32'h0};

  synce_clock_selector #(.MS_TICK_CYCLES(10)) synce_clock_selector_inst (
    .clk_sys(clk_sys), .rst(rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .ref_in(ref_in), .link_up(link_up),
    .ref_pll_locked(ref_pll_locked), .synth_clk(synth_clk),
    .tx_clk(tx_clk), .time_clk(time_clk), .selected(selected),
    .holdover(holdover), .irq(irq));
  ref_clock_model ref_clock_model_inst (.run(run), .ref_in(ref_in));

  // ------------------------------------------------------------
  // clock, timeout, helpers
  // ------------------------------------------------------------
  initial
  begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys)
  begin
    cycles <= cycles + 1;
    if (cycles == 40000)
    begin
      mismatches++;
      complete_run();
    end
  end
  function automatic logic [15:0] next_lfsr(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction
  // priority word with input i in the top slot
  function automatic logic [31:0] prio_for(input int i);
    return {24'h0, 2'(i + 3), 2'(i + 2), 2'(i + 1), 2'(i)};
  endfunction
  task automatic complete_run();
    $display("checks %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic chk(input string name, input logic [31:0] seen, exp);
    tests_run++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk_sys);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge clk_sys);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask
  // bounded wait for a selection or holdover state, n holds the wait
  task automatic wait_st(input logic [1:0] s, input logic h);
    n = 0;
    while (!(holdover === h && (h || selected === s)) && n < 4000)
    begin
      @(posedge clk_sys);
      n++;
    end
    #1;
    chk("holdover", holdover, h);
    if (!h)
      chk("selected", selected, s);
  endtask
  // counts toggles of tx_clk, or of time_clk when tm is set
  task automatic count_tx(input logic tm);
    n = 0;
    t = tm ? time_clk : tx_clk;
    repeat (200)
    begin
      @(posedge clk_sys);
      #1;
      if ((tm ? time_clk : tx_clk) !== t)
        n++;
      t = tm ? time_clk : tx_clk;
    end
  endtask

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial
  begin
    rst = 1'b1;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h0;
    reg_wdata = 32'h0;
    link_up = 4'hf;
    run = 4'hf;
    ref_pll_locked = 1'b1;
    mismatches = 0;
    tests_run = 0;
    lfsr = 16'hd095;
    repeat (4) @(posedge clk_sys);
    rst <= 1'b0;
    foreach (ra[i])
    begin
      rd(ra[i]);
      chk("reset value", d, rv[i]);
    end
    repeat (6)
    begin
      lfsr = next_lfsr(lfsr);
      wr(`ADDR_WTR, {16'h0, lfsr});
      rd(`ADDR_WTR);
      chk("wtr", d & 32'hffff, {16'h0, lfsr});
    end
    wr(`ADDR_WTR, 32'h5);
    wr(`ADDR_WINDOW, 32'h190);
    for (int i = 0; i < 4; i++)
      wr(8'(`ADDR_EXPECT_LO + i), 32'h60);
    wr(`ADDR_SYNTH_LO, 32'h10000000);
    wr(8'h1c, 32'h20000000);
    wr(`ADDR_INT_MASK, 32'h7);
    wr(`ADDR_CTRL, 32'h1);
    // qualify, restore and learn history over a few windows
    repeat (1500) @(posedge clk_sys);
    wait_st(2'h0, 1'b0);
    rd(`ADDR_STATUS);
    chk("state", d[7:2], 6'h3d);
    for (int i = 0; i < 4; i++)
    begin
      wr(`ADDR_PRIO, prio_for(i));
      wait_st(2'(i), 1'b0);
    end
    wr(`ADDR_PRIO, prio_for(0));
    wait_st(2'h0, 1'b0);
    wr(`ADDR_INT_STAT, 32'h7);
    rd(`ADDR_INT_STAT);
    chk("switch flag", d[1], 1'b0);
    link_up <= 4'he;
    repeat (10) @(posedge clk_sys);
    #1 chk("selected", selected, 2'h0);
    wait_st(2'h1, 1'b0);
    rd(`ADDR_INT_STAT);
    chk("switch flag", d[1], 1'b1);
    chk("irq", irq, 1'b1);
    wr(`ADDR_INT_MASK, 32'h0);
    repeat (2) @(posedge clk_sys);
    #1 chk("irq", irq, 1'b0);
    wr(`ADDR_INT_MASK, 32'h7);
    wr(`ADDR_CTRL, 32'h21);
    wait_st(2'h2, 1'b0);
    run <= 4'hb;
    wait_st(2'h3, 1'b0);
    rd(`ADDR_STATUS);
    chk("qualified", d[7:6], 2'h2);
    link_up <= 4'h0;
    wait_st(2'h0, 1'b1);
    rd(`ADDR_STATUS);
    chk("state", d[3:2], 2'h3);
    rd(`ADDR_INT_STAT);
    chk("holdover flag", d[0], 1'b1);
    rd(`ADDR_HOLD_FREQ);
    chk("history", d != 32'h0, 1'b1);
    count_tx(1'b0);
    chk("tx toggles", n > 10 && n < 40, 1'b1);
    wr(`ADDR_CTRL, 32'h25);
    count_tx(1'b1);
    chk("time toggles", n > 40 && n < 60, 1'b1);
    wr(8'h1f, 32'h9);
    rd(8'h1f);
    chk("synth cfg", d, 32'h9);
    wr(`ADDR_WTR, 32'h64);
    wr(`ADDR_CTRL, 32'h1);
    run <= 4'hf;
    link_up <= 4'hf;
    wait_st(2'h0, 1'b0);
    chk("restore wait", n > 990 && n < 1020, 1'b1);
    ref_pll_locked <= 1'b0;
    wait_st(2'h0, 1'b1);
    complete_run();
  end
endmodule // synce_clock_selector_bench
